// [src/swire_dev.sv]
`timescale 1ns/1ns
`default_nettype none
`include "swire_cfg.svh"
module swire_dev (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  swire_if.dev link,
  output logic mem_unlocked,
  output logic prog_detect,
  output logic prog_done
);

  localparam logic [55:0] ID56 = {`SERIAL_NUM, `FAMILY_CODE};
  localparam logic [63:0] ROM_ID = {swire_pkg::crc8_of56(ID56), ID56};

  swire_pkg::dev_state_t state_reg;
  logic [6:0] bit_cnt_reg;
  logic [1:0] phase_reg;
  logic [7:0] sh_reg, cmd_reg, crc_reg, wdata_reg;
  logic [15:0] addr_reg;
  logic [7:0] main_mem [`MAIN_BYTES];
  logic [7:0] stat_mem [`STAT_BYTES];
  logic rx, tx_bit, tx_en, byte_done, stat_sel, write_cmd, at_end, page_prot, id_bit, prog_fire;
  logic [7:0] sh_next, cur_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign rx = link.line;
  assign byte_done = (bit_cnt_reg[2:0] == 3'h7);
  assign sh_next = {rx, sh_reg[7:1]};
  assign id_bit = ROM_ID[bit_cnt_reg[5:0]];
  assign stat_sel = (cmd_reg == `MEM_STATUS) || (cmd_reg == `MEM_WSTATUS);
  assign write_cmd = (cmd_reg == `MEM_WRITE) || (cmd_reg == `MEM_WSTATUS);
  assign cur_byte = stat_sel ? stat_mem[addr_reg[2:0]] : main_mem[addr_reg[6:0]];
  assign at_end = addr_reg >= (stat_sel ? `STAT_LAST : `MAIN_LAST);
  // Page index is address bits 6:5, 32 bytes each
  assign page_prot = ~stat_mem[0][addr_reg[6:5]];
  assign prog_fire = (state_reg == swire_pkg::D_PROG) && prog_detect;

  always_comb
  begin
    tx_en = 1'b0;
    tx_bit = 1'b1;
    case (state_reg)
      swire_pkg::D_ROMTX:
      begin
        tx_en = 1'b1;
        tx_bit = id_bit;
      end
      swire_pkg::D_SEARCH:
      begin
        tx_en = (phase_reg != 2'h2);
        tx_bit = id_bit ^ phase_reg[0];
      end
      swire_pkg::D_CRCTX:
      begin
        tx_en = 1'b1;
        tx_bit = crc_reg[bit_cnt_reg[2:0]];
      end
      swire_pkg::D_READ:
      begin
        tx_en = (phase_reg != 2'h2);
        tx_bit = (phase_reg == 2'h0) ? cur_byte[bit_cnt_reg[2:0]] : crc_reg[bit_cnt_reg[2:0]];
      end
      default:
        tx_en = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line drivers

  // Registered drive: host must space slots at least two cycles apart
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      link.dev_low <= 1'b0;
    else if (ce)
      link.dev_low <= tx_en & ~tx_bit & ~link.bus_reset;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      link.presence <= 1'b0;
    else if (ce)
      link.presence <= link.bus_reset;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      prog_detect <= 1'b0;
    else if (ce)
      prog_detect <= link.prog_volt;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      prog_done <= 1'b0;
    else if (ce)
      prog_done <= prog_fire && !link.bus_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol sequencer

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg <= swire_pkg::D_IDLE;
      bit_cnt_reg <= 7'h00;
      phase_reg <= 2'h0;
      sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      crc_reg <= `CRC_INIT;
      wdata_reg <= `ERASED_BYTE;
      addr_reg <= 16'h0000;
      mem_unlocked <= 1'b0;
    end
    else if (ce)
    begin
      if (link.bus_reset)
      begin
        state_reg <= swire_pkg::D_ROMCMD;
        bit_cnt_reg <= 7'h00;
        phase_reg <= 2'h0;
        mem_unlocked <= 1'b0;
      end
      else if (prog_fire)
        state_reg <= swire_pkg::D_IDLE;
      else if (link.slot)
      begin
        case (state_reg)
          swire_pkg::D_ROMCMD:
          begin
            sh_reg <= sh_next;
            bit_cnt_reg <= byte_done ? 7'h00 : bit_cnt_reg + 7'h01;
            crc_reg <= `CRC_INIT;
            if (byte_done)
            begin
              case (sh_next)
                `ROM_READ: state_reg <= swire_pkg::D_ROMTX;
                `ROM_MATCH: state_reg <= swire_pkg::D_MATCH;
                `ROM_SEARCH: state_reg <= swire_pkg::D_SEARCH;
                `ROM_SKIP:
                begin
                  state_reg <= swire_pkg::D_MEMCMD;
                  mem_unlocked <= 1'b1;
                end
                default: state_reg <= swire_pkg::D_IDLE;
              endcase
            end
          end
          swire_pkg::D_ROMTX, swire_pkg::D_MATCH, swire_pkg::D_SEARCH:
          begin
            if ((state_reg == swire_pkg::D_SEARCH) && (phase_reg != 2'h2))
              phase_reg <= phase_reg + 2'h1;
            else if ((state_reg != swire_pkg::D_ROMTX) && (rx != id_bit))
              state_reg <= swire_pkg::D_IDLE;
            else
            begin
              phase_reg <= 2'h0;
              bit_cnt_reg <= bit_cnt_reg + 7'h01;
              if (bit_cnt_reg == `ID_LAST)
              begin
                bit_cnt_reg <= 7'h00;
                state_reg <= swire_pkg::D_MEMCMD;
                mem_unlocked <= 1'b1;
              end
            end
          end
          swire_pkg::D_MEMCMD:
          begin
            sh_reg <= sh_next;
            crc_reg <= swire_pkg::crc8_step(crc_reg, rx);
            bit_cnt_reg <= byte_done ? 7'h00 : bit_cnt_reg + 7'h01;
            if (byte_done)
            begin
              cmd_reg <= sh_next;
              case (sh_next)
                `MEM_READ, `MEM_STATUS, `MEM_READ_CRC, `MEM_WRITE, `MEM_WSTATUS:
                  state_reg <= swire_pkg::D_ADDR;
                default: state_reg <= swire_pkg::D_IDLE;
              endcase
            end
          end
          swire_pkg::D_ADDR:
          begin
            addr_reg <= {rx, addr_reg[15:1]};
            crc_reg <= swire_pkg::crc8_step(crc_reg, rx);
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
            if (bit_cnt_reg == 7'h0F)
            begin
              bit_cnt_reg <= 7'h00;
              state_reg <= write_cmd ? swire_pkg::D_WDATA : swire_pkg::D_CRCTX;
            end
          end
          swire_pkg::D_WDATA:
          begin
            sh_reg <= sh_next;
            crc_reg <= swire_pkg::crc8_step(crc_reg, rx);
            bit_cnt_reg <= byte_done ? 7'h00 : bit_cnt_reg + 7'h01;
            if (byte_done)
            begin
              wdata_reg <= sh_next;
              state_reg <= swire_pkg::D_CRCTX;
            end
          end
          swire_pkg::D_CRCTX:
          begin
            bit_cnt_reg <= byte_done ? 7'h00 : bit_cnt_reg + 7'h01;
            if (byte_done)
            begin
              // Data CRC restarts after the header CRC
              crc_reg <= `CRC_INIT;
              phase_reg <= 2'h0;
              state_reg <= write_cmd ? swire_pkg::D_PROG : swire_pkg::D_READ;
            end
          end
          swire_pkg::D_READ:
          begin
            if (phase_reg != 2'h2)
              bit_cnt_reg <= byte_done ? 7'h00 : bit_cnt_reg + 7'h01;
            if (phase_reg == 2'h0)
              crc_reg <= swire_pkg::crc8_step(crc_reg, tx_bit);
            if (byte_done && (phase_reg == 2'h0))
            begin
              if (at_end)
                phase_reg <= 2'h1;
              else
                addr_reg <= addr_reg + 16'h0001;
            end
            else if (byte_done && (phase_reg == 2'h1))
              phase_reg <= 2'h2;
          end
          default:
            state_reg <= state_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Add-only storage

  // Contents reload on chip reset; no retention model
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < `MAIN_BYTES; i++)
        main_mem[i] <= `ERASED_BYTE;
      for (int j = 0; j < `STAT_BYTES; j++)
        stat_mem[j] <= (j < 5) ? `REDIR_VALID : `FACTORY_TAIL;
    end
    else if (ce && prog_fire && !link.bus_reset)
    begin
      if (stat_sel)
        stat_mem[addr_reg[2:0]] <= stat_mem[addr_reg[2:0]] & wdata_reg;
      else if (!page_prot)
        main_mem[addr_reg[6:0]] <= main_mem[addr_reg[6:0]] & wdata_reg;
    end
  end

endmodule : swire_dev
`default_nettype wire

// [src/swire_cfg.svh]
// Summary of operation
// - Identity is family, serial, check byte
// - Check byte is CRC of first 56 bits
// - CRC polynomial x^8 + x^5 + x^4 + 1
// - Accumulator starts at zero
// - Family LSB first, then serial, bitwise
// - Receiver shifts check byte, expects zero
// - Memory locked until identity command completes
// - Master opens with one identity command
// - Five memory commands once unlocked
// - All bytes travel LSB first
// - Programming only clears bits
// - Programming voltage raises internal detect
// - Programming pulse follows normal command traffic
// - Four pages of 256 bits
// - Protected page refuses programming
// - Presence pulse answers bus reset
// - Redirect byte all ones means page valid
`ifndef SWIRE_CFG_SVH
`define SWIRE_CFG_SVH

`define ROM_READ 8'h33
`define ROM_MATCH 8'h55
`define ROM_SEARCH 8'hF0
`define ROM_SKIP 8'hCC

`define MEM_READ 8'hF0
`define MEM_STATUS 8'hAA
`define MEM_READ_CRC 8'hC3
`define MEM_WRITE 8'h0F
`define MEM_WSTATUS 8'h55

`define CRC_TAPS 8'h8C
`define CRC_INIT 8'h00

`define MAIN_BYTES 128
`define STAT_BYTES 8
`define MAIN_LAST 16'h007F
`define STAT_LAST 16'h0007
`define ERASED_BYTE 8'hFF
`define FACTORY_TAIL 8'h00
`define REDIR_VALID 8'hFF
`define ID_LAST 7'h3F

// Arbitrary identity values
`define FAMILY_CODE 8'h5A
`define SERIAL_NUM 48'h0000_1234_5678

`define SLOT_GAP 4'h3
`define RST_WAIT 4'h4
`define PROG_CYC 4'h8

`endif

// [src/swire_pkg.sv]
`default_nettype none
`include "swire_cfg.svh"
package swire_pkg;

  typedef enum logic [10:0] {
    D_IDLE = 11'h001,
    D_ROMCMD = 11'h002,
    D_ROMTX = 11'h004,
    D_MATCH = 11'h008,
    D_SEARCH = 11'h010,
    D_MEMCMD = 11'h020,
    D_ADDR = 11'h040,
    D_WDATA = 11'h080,
    D_CRCTX = 11'h100,
    D_READ = 11'h200,
    D_PROG = 11'h400
  } dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_RST = 5'h02,
    H_SLOT = 5'h04,
    H_GAP = 5'h08,
    H_PROG = 5'h10
  } host_state_t;

  typedef enum logic [1:0] {
    OP_RESET = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2,
    OP_PROG = 2'h3
  } host_op_t;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = b ^ crc[0];
    crc8_step = (crc >> 1) ^ (fb ? `CRC_TAPS : 8'h00);
  endfunction : crc8_step

  function automatic logic [7:0] crc8_of56(input logic [55:0] d);
    logic [7:0] c;
    c = `CRC_INIT;
    for (int i = 0; i < 56; i++)
    begin
      c = crc8_step(c, d[i]);
    end
    crc8_of56 = c;
  endfunction : crc8_of56

endpackage : swire_pkg
`default_nettype wire

// [src/swire_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface swire_if;
  logic bus_reset;
  logic slot;
  logic host_bit;
  logic prog_volt;
  logic dev_low;
  logic presence;
  logic line;

  // Wired-AND: either end pulls the line low
  assign line = host_bit & ~dev_low;

  modport dev (
    input bus_reset,
    input slot,
    input line,
    input prog_volt,
    output dev_low,
    output presence
  );

  modport host (
    output bus_reset,
    output slot,
    output host_bit,
    output prog_volt,
    input line,
    input presence
  );
endinterface : swire_if
`default_nettype wire

// [src/swire_host.sv]
`timescale 1ns/1ns
`default_nettype none
`include "swire_cfg.svh"
module swire_host (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  swire_if.host link,
  input wire logic start,
  input wire swire_pkg::host_op_t op,
  input wire logic [7:0] wdata,
  input wire logic crc_clr,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic presence_seen,
  output logic [7:0] crc_val
);

  swire_pkg::host_state_t state_reg;
  logic [7:0] sh_reg;
  logic [7:0] rsh_reg;
  logic [2:0] bit_cnt_reg;
  logic [3:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_reg <= swire_pkg::H_IDLE;
      sh_reg <= 8'hFF;
      rsh_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      cnt_reg <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      presence_seen <= 1'b0;
      link.bus_reset <= 1'b0;
      link.slot <= 1'b0;
      link.host_bit <= 1'b1;
      link.prog_volt <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      case (state_reg)
        swire_pkg::H_IDLE:
        begin
          // Start while busy is never seen here
          if (start)
          begin
            busy <= 1'b1;
            bit_cnt_reg <= 3'h0;
            case (op)
              swire_pkg::OP_RESET:
              begin
                link.bus_reset <= 1'b1;
                presence_seen <= 1'b0;
                cnt_reg <= `RST_WAIT;
                state_reg <= swire_pkg::H_RST;
              end
              swire_pkg::OP_PROG:
              begin
                link.prog_volt <= 1'b1;
                cnt_reg <= `PROG_CYC;
                state_reg <= swire_pkg::H_PROG;
              end
              default:
              begin
                // Read slots send a one and let the device pull low
                sh_reg <= (op == swire_pkg::OP_WRITE) ? wdata : 8'hFF;
                link.host_bit <= (op == swire_pkg::OP_WRITE) ? wdata[0] : 1'b1;
                link.slot <= 1'b1;
                state_reg <= swire_pkg::H_SLOT;
              end
            endcase
          end
        end
        swire_pkg::H_RST:
        begin
          link.bus_reset <= 1'b0;
          if (link.presence)
            presence_seen <= 1'b1;
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state_reg <= swire_pkg::H_IDLE;
          end
        end
        swire_pkg::H_SLOT:
        begin
          rsh_reg <= {link.line, rsh_reg[7:1]};
          sh_reg <= {1'b1, sh_reg[7:1]};
          link.slot <= 1'b0;
          link.host_bit <= 1'b1;
          cnt_reg <= `SLOT_GAP;
          state_reg <= swire_pkg::H_GAP;
        end
        swire_pkg::H_GAP:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            if (bit_cnt_reg == 3'h7)
            begin
              rdata <= rsh_reg;
              busy <= 1'b0;
              done <= 1'b1;
              state_reg <= swire_pkg::H_IDLE;
            end
            else
            begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              link.host_bit <= sh_reg[0];
              link.slot <= 1'b1;
              state_reg <= swire_pkg::H_SLOT;
            end
          end
        end
        swire_pkg::H_PROG:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            link.prog_volt <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state_reg <= swire_pkg::H_IDLE;
          end
        end
        default:
          state_reg <= swire_pkg::H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Running CRC over every bit on the line

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      crc_val <= `CRC_INIT;
    else if (ce)
    begin
      if (crc_clr && (state_reg == swire_pkg::H_IDLE))
        crc_val <= `CRC_INIT;
      else if (state_reg == swire_pkg::H_SLOT)
        crc_val <= swire_pkg::crc8_step(crc_val, link.line);
    end
  end

endmodule : swire_host
`default_nettype wire

// [test/swire_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module swire_assertions (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic bus_reset,
  input wire logic slot,
  input wire logic host_bit,
  input wire logic prog_volt,
  input wire logic presence,
  input wire logic dev_low
);
  default clocking cb @(posedge clock); endclocking
  // Frozen cycles carry no protocol timing
  default disable iff (!rst_b || !ce);

  ////////////////////////////////////////////////////////////////////////////
  // Programming pulse shape, built in steps
  sequence prog_rise;
    !prog_volt ##1 prog_volt;
  endsequence
  sequence prog_hold;
    prog_volt[*8] ##1 prog_volt ##1 !prog_volt;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_presence_follows:
    assert property (bus_reset |=> presence) else $error("no presence after bus reset");
  a_presence_cause:
    assert property (presence |-> $past(bus_reset)) else $error("presence without bus reset");
  a_presence_single:
    assert property (presence |=> !presence) else $error("presence longer than one cycle");
  a_prog_width:
    assert property (prog_rise |-> prog_hold) else $error("programming pulse width wrong");
  a_prog_quiet:
    assert property (prog_volt |-> !slot && !bus_reset) else $error("traffic during programming");
  a_slot_idle_high:
    assert property (slot |=> host_bit) else $error("line not released after slot");
  a_slot_spacing:
    assert property (slot |=> !slot ##1 !slot) else $error("slots too close");
  // Reset must win, so a slot in the same cycle would be lost
  a_reset_no_slot:
    assert property (bus_reset |-> !slot) else $error("slot with bus reset");
  a_reset_release:
    assert property (bus_reset |=> !dev_low) else $error("line held low after bus reset");
  a_prog_no_pull:
    assert property (prog_volt |-> !dev_low) else $error("line pulled during programming");
endmodule : swire_assertions
`default_nettype wire

// [test/single_wire_rom_id_crc_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "swire_cfg.svh"
module single_wire_rom_id_crc_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  swire_pkg::host_op_t op = swire_pkg::OP_RESET;
  logic [7:0] wdata = 8'h00;
  logic crc_clr = 1'b0;
  logic busy, done, presence_seen, mem_unlocked, prog_detect, prog_done;
  logic [7:0] rdata, crc_val;
  logic [63:0] wire_bits = 64'h0000_0000_0000_0000;
  logic prog_seen = 1'b0;
  logic detect_seen = 1'b0;
  int failures = 0;
  int compares = 0;

  // Own bitwise model, kept apart from the design's helpers
  function automatic logic [7:0] id_crc(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
    begin
      c = {1'b0, c[7:1]} ^ ((d[i] ^ c[0]) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction : id_crc

  logic [63:0] id;
  assign id = {id_crc({`SERIAL_NUM, `FAMILY_CODE}), `SERIAL_NUM, `FAMILY_CODE};

  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  swire_if swire_if_i ();
  swire_dev swire_dev_i (.clock(clock), .rst_b(rst_b), .ce(ce), .link(swire_if_i.dev),
    .mem_unlocked(mem_unlocked), .prog_detect(prog_detect), .prog_done(prog_done));
  swire_host swire_host_i (.clock(clock), .rst_b(rst_b), .ce(ce), .link(swire_if_i.host),
    .start(start), .op(op), .wdata(wdata), .crc_clr(crc_clr), .busy(busy), .done(done),
    .rdata(rdata), .presence_seen(presence_seen), .crc_val(crc_val));
  swire_assertions swire_assertions_i (.clock(clock), .rst_b(rst_b), .ce(ce),
    .bus_reset(swire_if_i.bus_reset), .slot(swire_if_i.slot), .host_bit(swire_if_i.host_bit),
    .prog_volt(swire_if_i.prog_volt), .presence(swire_if_i.presence), .dev_low(swire_if_i.dev_low));

  // Wire view: last 64 slot values, first bit ends up lowest
  always @(posedge clock)
  begin
    if (swire_if_i.slot === 1'b1) wire_bits <= {swire_if_i.line, wire_bits[63:1]};
    if (prog_done === 1'b1) prog_seen <= 1'b1;
    if (prog_detect === 1'b1) detect_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic run_op(input swire_pkg::host_op_t o, input logic [7:0] d);
    int n;
    n = 0;
    op = o;
    wdata = d;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    while (done !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 100) chk(64'h0, 64'h1);
  endtask : run_op

  task automatic clr_crc();
    crc_clr = 1'b1;
    @(negedge clock);
    crc_clr = 1'b0;
  endtask : clr_crc

  task automatic write_mem(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] d);
    run_op(swire_pkg::OP_RESET, 8'h00);
    run_op(swire_pkg::OP_WRITE, 8'hCC);
    clr_crc();
    run_op(swire_pkg::OP_WRITE, cmd);
    run_op(swire_pkg::OP_WRITE, addr);
    run_op(swire_pkg::OP_WRITE, 8'h00);
    run_op(swire_pkg::OP_WRITE, d);
    run_op(swire_pkg::OP_READ, 8'hFF);
    chk(crc_val, 8'h00);
    run_op(swire_pkg::OP_PROG, 8'h00);
  endtask : write_mem

  task automatic read_mem(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] exp);
    run_op(swire_pkg::OP_RESET, 8'h00);
    run_op(swire_pkg::OP_WRITE, 8'hCC);
    run_op(swire_pkg::OP_WRITE, cmd);
    run_op(swire_pkg::OP_WRITE, addr);
    run_op(swire_pkg::OP_WRITE, 8'h00);
    run_op(swire_pkg::OP_READ, 8'hFF);
    run_op(swire_pkg::OP_READ, 8'hFF);
    chk(rdata, exp);
  endtask : read_mem

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_rom_cmds();
    logic [7:0] cmds [4] = '{8'h33, 8'h55, 8'hF0, 8'hCC};
    logic [191:0] s;
    for (int i = 0; i < 64; i++) s[3*i+:3] = {id[i], 2'b11};
    foreach (cmds[c])
    begin
      run_op(swire_pkg::OP_RESET, 8'h00);
      chk(presence_seen, 1'b1);
      chk(mem_unlocked, 1'b0);
      run_op(swire_pkg::OP_WRITE, cmds[c]);
      clr_crc();
      if (c == 0)
      begin
        for (int b = 0; b < 8; b++)
        begin
          run_op(swire_pkg::OP_READ, 8'hFF);
          chk(rdata, id[8*b+:8]);
        end
        chk(crc_val, 8'h00);
        chk(wire_bits, id);
      end
      if (c == 1) for (int b = 0; b < 8; b++) run_op(swire_pkg::OP_WRITE, id[8*b+:8]);
      // Read slots are write slots of one, so search fits in bytes
      if (c == 2) for (int b = 0; b < 24; b++) run_op(swire_pkg::OP_WRITE, s[8*b+:8]);
      chk(mem_unlocked, 1'b1);
    end
    $display("test_rom_cmds finished");
  endtask : test_rom_cmds

  task automatic test_locked();
    run_op(swire_pkg::OP_RESET, 8'h00);
    run_op(swire_pkg::OP_WRITE, 8'hAA);
    run_op(swire_pkg::OP_WRITE, 8'hF0);
    chk(mem_unlocked, 1'b0);
    run_op(swire_pkg::OP_READ, 8'hFF);
    chk(rdata, 8'hFF);
    $display("test_locked finished");
  endtask : test_locked

  task automatic test_program();
    write_mem(8'h0F, 8'h05, 8'hA5);
    chk({prog_seen, detect_seen}, 2'b11);
    read_mem(8'hF0, 8'h05, 8'hA5);
    write_mem(8'h0F, 8'h05, 8'h5F);
    read_mem(8'hC3, 8'h05, 8'h05);
    $display("test_program finished");
  endtask : test_program

  task automatic test_protect();
    write_mem(8'h55, 8'h00, 8'hFE);
    write_mem(8'h0F, 8'h05, 8'h00);
    read_mem(8'hF0, 8'h05, 8'h05);
    write_mem(8'h0F, 8'h25, 8'h00);
    read_mem(8'hF0, 8'h25, 8'h00);
    $display("test_protect finished");
  endtask : test_protect

  // Whole status field, its data check byte, then idle ones
  task automatic test_status();
    logic [7:0] exp [8] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    run_op(swire_pkg::OP_RESET, 8'h00);
    run_op(swire_pkg::OP_WRITE, 8'hCC);
    run_op(swire_pkg::OP_WRITE, 8'hAA);
    run_op(swire_pkg::OP_WRITE, 8'h00);
    run_op(swire_pkg::OP_WRITE, 8'h00);
    run_op(swire_pkg::OP_READ, 8'hFF);
    clr_crc();
    for (int b = 0; b < 8; b++)
    begin
      run_op(swire_pkg::OP_READ, 8'hFF);
      chk(rdata, exp[b]);
    end
    run_op(swire_pkg::OP_READ, 8'hFF);
    chk(crc_val, 8'h00);
    run_op(swire_pkg::OP_READ, 8'hFF);
    chk(rdata, 8'hFF);
    $display("test_status finished");
  endtask : test_status

  // Clock enable low must hold both ends mid bus reset
  task automatic test_freeze();
    int n;
    n = 0;
    op = swire_pkg::OP_RESET;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    ce = 1'b0;
    repeat (20) @(negedge clock);
    chk({busy, done, presence_seen}, 3'b100);
    ce = 1'b1;
    while (done !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    chk({n < 100, busy, presence_seen}, 3'b101);
    $display("test_freeze finished");
  endtask : test_freeze

  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    test_rom_cmds();
    test_locked();
    test_freeze();
    test_program();
    test_protect();
    test_status();
    complete_run();
  end

  // Tests need about 5000 cycles; generous margin
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    complete_run();
  end
endmodule : single_wire_rom_id_crc_tb
`default_nettype wire
